// >>> tec_calc.sv
// Energy calculator core: accumulators, unit conversion, sensor-fault gating,
// reconfiguration log and the laboratory test mode with its key handling.
// Assumes measurement inputs are synchronous to core_clk; seal contact and key are pins.

////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE_01: Test entry only while seal contact shorted.
// RULE_02: Nine hour timeout returns to first reading.
// RULE_03: Five second hold then release exits test.
// RULE_04: Brief press advances; long press toggles secondary.
// RULE_05: Count reconfigurations, refuse beyond twenty five.
// RULE_06: High-resolution counts in 1 Wh, 10 ml.
// RULE_07: High-resolution registers cleared only by total reset.
// RULE_08: All four energies evaluated every integration.
// RULE_09: Weighted registers add volume times temperature.
// RULE_10: Weighted registers scaled by volume resolution.
// RULE_11: Wh converted to kWh, MWh or GJ.
// RULE_12: Heat accumulates only when inlet above outlet.
// RULE_13: Cooling accumulates only when inlet below outlet.
// RULE_14: Equal temperatures add nothing to either.
// RULE_15: Coefficient taken at flow sensor position.
// RULE_16: Sensor errors stop the affected counters.
// RULE_17: Affected readings show dashes.
// RULE_18: Threshold splits heat and cooling by inlet.
// RULE_19: Long press threshold shorter than exit hold.
module tec_calc #(
    parameter logic [47:0] TIMEOUT_CYC = 48'(tec_pkg::TEST_TIMEOUT_CYC),
    parameter logic [47:0] EXIT_CYC    = 48'(tec_pkg::EXIT_HOLD_CYC),
    parameter logic [47:0] LONG_CYC    = 48'(tec_pkg::LONG_HOLD_CYC)
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    // Measurement and configuration
    input  wire tec_pkg::tec_meas_t  meas,
    input  wire tec_pkg::tec_cfg_t   cfg,
    input  wire logic                total_reset_req,
    input  wire logic                reconfig_req,
    // Pins and menu
    input  wire logic                test_contact_pin,
    input  wire logic                key_pin,
    input  wire logic                test_req,
    // Test mode state
    output logic                     test_mode,
    output logic                     exit_prompt,
    output logic [2:0]               reading_idx,
    output logic                     secondary,
    // Readings
    output logic [31:0]              heat_energy_acc,
    output logic [31:0]              cooling_energy_acc,
    output logic [31:0]              inlet_weighted_acc,
    output logic [31:0]              outlet_weighted_acc,
    output logic [31:0]              heat_hires_wh,
    output logic [31:0]              cool_hires_wh,
    output logic [31:0]              volume_hires,
    output tec_pkg::tec_dash_t       dash,
    // Reconfiguration log
    output logic [4:0]               reconfig_count,
    output logic                     reconfig_ack,
    output logic                     reconfig_refused
);

    function automatic logic [31:0] div32(input logic [63:0] a, input logic [63:0] d);
        logic [63:0] q;
        q = a / d;
        return q[31:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: level changes once second and third stages agree
    logic [2:0] key_sync_ff, contact_sync_ff;
    logic       key_lvl_ff, contact_lvl_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            key_sync_ff     <= 3'h0;
            contact_sync_ff <= 3'h0;
            key_lvl_ff      <= 1'b0;
            contact_lvl_ff  <= 1'b0;
        end else begin
            key_sync_ff     <= {key_sync_ff[1:0], key_pin};
            contact_sync_ff <= {contact_sync_ff[1:0], test_contact_pin};
            if (key_sync_ff[1] == key_sync_ff[2]) key_lvl_ff <= key_sync_ff[2];
            if (contact_sync_ff[1] == contact_sync_ff[2]) contact_lvl_ff <= contact_sync_ff[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath: raw accumulators and registered readings
    logic [63:0] heat_raw_ff, cool_raw_ff, inw_raw_ff, outw_raw_ff, vol_raw_ff;
    logic [63:0] nxt_heat_raw, nxt_cool_raw, nxt_inw_raw, nxt_outw_raw, nxt_vol_raw;
    logic        heat_ok, cool_ok, inw_ok, outw_ok, vol_ok;
    logic [15:0] dt_heat, dt_cool;
    logic [20:0] k_sel;
    logic [63:0] unit_div, wdiv;
    logic [31:0] heat_wh, cool_wh;

    always_comb begin
        // Coefficient at the mounting position of the flow sensor
        k_sel   = cfg.flow_at_outlet ? meas.k_outlet : meas.k_inlet;  // [RULE_15]
        dt_heat = meas.inlet_temp - meas.outlet_temp;
        dt_cool = meas.outlet_temp - meas.inlet_temp;
        // Strict compares leave equal temperatures out of both  [RULE_14]
        heat_ok = !meas.inlet_err && !meas.outlet_err && !meas.flow_err
                  && (meas.inlet_temp > meas.outlet_temp)              // [RULE_12]
                  && (!cfg.thr_en || meas.inlet_temp >= cfg.heat_cool_threshold); // [RULE_18]
        cool_ok = !meas.inlet_err && !meas.outlet_err && !meas.flow_err
                  && (meas.inlet_temp < meas.outlet_temp)              // [RULE_13]
                  && (!cfg.thr_en || meas.inlet_temp < cfg.heat_cool_threshold); // [RULE_18]
        inw_ok  = !meas.inlet_err && !meas.flow_err;                   // [RULE_16]
        outw_ok = !meas.outlet_err && !meas.flow_err;                  // [RULE_16]
        vol_ok  = !meas.flow_err;                                      // [RULE_16]
        nxt_heat_raw = heat_raw_ff;
        nxt_cool_raw = cool_raw_ff;
        nxt_inw_raw  = inw_raw_ff;
        nxt_outw_raw = outw_raw_ff;
        nxt_vol_raw  = vol_raw_ff;
        if (total_reset_req) begin
            // Only a total reset clears the high-resolution counts  [RULE_07]
            nxt_heat_raw = 64'h0;
            nxt_cool_raw = 64'h0;
            nxt_inw_raw  = 64'h0;
            nxt_outw_raw = 64'h0;
            nxt_vol_raw  = 64'h0;
        end else if (meas.vol_step) begin
            // All four evaluated side by side on every step  [RULE_08]
            if (heat_ok)
                nxt_heat_raw = heat_raw_ff + 64'(meas.flow_volume) * 64'(dt_heat) * 64'(k_sel);
            if (cool_ok)
                nxt_cool_raw = cool_raw_ff + 64'(meas.flow_volume) * 64'(dt_cool) * 64'(k_sel);
            if (inw_ok)                                                // [RULE_09]
                nxt_inw_raw = inw_raw_ff + 64'(meas.flow_volume) * 64'(meas.inlet_temp);
            if (outw_ok)                                               // [RULE_09]
                nxt_outw_raw = outw_raw_ff + 64'(meas.flow_volume) * 64'(meas.outlet_temp);
            if (vol_ok)
                nxt_vol_raw = vol_raw_ff + 64'(meas.flow_volume);      // [RULE_06]
        end
        // Wh first, then the selected unit  [RULE_11]
        heat_wh = div32(heat_raw_ff, tec_pkg::WH_SCALE);               // [RULE_06]
        cool_wh = div32(cool_raw_ff, tec_pkg::WH_SCALE);               // [RULE_06]
        unique case (cfg.energy_unit)
            tec_pkg::UNIT_KWH: unit_div = tec_pkg::DIV_KWH;
            tec_pkg::UNIT_MWH: unit_div = tec_pkg::DIV_MWH;
            tec_pkg::UNIT_GJ:  unit_div = tec_pkg::DIV_GJ;
            tec_pkg::UNIT_WH:  unit_div = 64'h1;
        endcase
        unique case (cfg.flow_size_code)                               // [RULE_10]
            2'h0: wdiv = tec_pkg::WDIV_RES0;
            2'h1: wdiv = tec_pkg::WDIV_RES1;
            2'h2: wdiv = tec_pkg::WDIV_RES2;
            2'h3: wdiv = tec_pkg::WDIV_RES3;
        endcase
    end

    // Readings lag the raw counts by one clock; dividers are large but off the count path
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            heat_raw_ff         <= 64'h0;
            cool_raw_ff         <= 64'h0;
            inw_raw_ff          <= 64'h0;
            outw_raw_ff         <= 64'h0;
            vol_raw_ff          <= 64'h0;
            heat_energy_acc     <= 32'h0;
            cooling_energy_acc  <= 32'h0;
            inlet_weighted_acc  <= 32'h0;
            outlet_weighted_acc <= 32'h0;
            heat_hires_wh       <= 32'h0;
            cool_hires_wh       <= 32'h0;
            volume_hires        <= 32'h0;
            dash                <= '0;
        end else begin
            heat_raw_ff         <= nxt_heat_raw;
            cool_raw_ff         <= nxt_cool_raw;
            inw_raw_ff          <= nxt_inw_raw;
            outw_raw_ff         <= nxt_outw_raw;
            vol_raw_ff          <= nxt_vol_raw;
            heat_energy_acc     <= div32(64'(heat_wh), unit_div);
            cooling_energy_acc  <= div32(64'(cool_wh), unit_div);
            inlet_weighted_acc  <= div32(inw_raw_ff, wdiv);
            outlet_weighted_acc <= div32(outw_raw_ff, wdiv);
            heat_hires_wh       <= heat_wh;
            cool_hires_wh       <= cool_wh;
            volume_hires        <= vol_raw_ff[31:0];
            dash.inlet          <= meas.inlet_err;                     // [RULE_17]
            dash.outlet         <= meas.outlet_err;                    // [RULE_17]
            dash.delta_t        <= meas.inlet_err | meas.outlet_err;   // [RULE_17]
            dash.flow           <= meas.flow_err;                      // [RULE_17]
            dash.power          <= meas.inlet_err | meas.outlet_err | meas.flow_err;
            dash.heat           <= meas.inlet_err | meas.outlet_err | meas.flow_err;
            dash.cool           <= meas.inlet_err | meas.outlet_err | meas.flow_err;
            dash.inlet_w        <= meas.inlet_err | meas.flow_err;
            dash.outlet_w       <= meas.outlet_err | meas.flow_err;
            dash.volume         <= meas.flow_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control: test mode, key classification, reconfiguration log
    tec_pkg::tec_state_t state_ff, nxt_state;
    logic [47:0] hold_ff, nxt_hold, tmo_ff, nxt_tmo;
    logic        key_prev_ff, key_release, timeout_hit;
    logic [2:0]  nxt_idx;
    logic        nxt_sec, nxt_ack, nxt_refused;
    logic [4:0]  nxt_rcount;

    always_comb begin
        nxt_state   = state_ff;
        nxt_idx     = reading_idx;
        nxt_sec     = secondary;
        nxt_tmo     = tmo_ff;
        key_release = key_prev_ff && !key_lvl_ff;
        timeout_hit = (tmo_ff == TIMEOUT_CYC - 48'h1);
        // Hold time saturates at the exit hold so the counter cannot wrap
        nxt_hold    = !key_lvl_ff ? 48'h0 : (hold_ff < EXIT_CYC ? hold_ff + 48'h1 : hold_ff);
        unique case (state_ff)
            tec_pkg::ST_USER: begin
                nxt_tmo = 48'h0;
                if (test_req && contact_lvl_ff) begin                  // [RULE_01]
                    nxt_state = tec_pkg::ST_TEST;
                    nxt_idx   = 3'h0;
                    nxt_sec   = 1'b0;
                end
            end
            tec_pkg::ST_TEST: begin
                nxt_tmo = tmo_ff + 48'h1;
                if (timeout_hit || (key_release && hold_ff >= EXIT_CYC)) begin // [RULE_02] [RULE_03]
                    nxt_state = tec_pkg::ST_USER;
                    nxt_idx   = 3'h0;
                    nxt_sec   = 1'b0;
                end else if (key_release && hold_ff >= LONG_CYC) begin  // [RULE_19]
                    nxt_sec = !secondary;                              // [RULE_04]
                    if (reading_idx > tec_pkg::LAST_SECOND) nxt_idx = 3'h0;
                end else if (key_release) begin                        // [RULE_04]
                    if (secondary)
                        nxt_idx = (reading_idx >= tec_pkg::LAST_SECOND) ? 3'h0 : reading_idx + 3'h1;
                    else
                        nxt_idx = (reading_idx >= tec_pkg::LAST_READING) ? 3'h0 : reading_idx + 3'h1;
                end
            end
            default: begin
                nxt_state = tec_pkg::ST_USER;
                nxt_tmo   = 48'h0;
            end
        endcase
        // Every attempt is counted until the limit; later ones are refused
        nxt_ack     = reconfig_req && (reconfig_count < tec_pkg::RECONF_MAX); // [RULE_05]
        nxt_refused = reconfig_req && (reconfig_count >= tec_pkg::RECONF_MAX); // [RULE_05]
        nxt_rcount  = nxt_ack ? reconfig_count + 5'h1 : reconfig_count;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff         <= tec_pkg::ST_USER;
            hold_ff          <= 48'h0;
            tmo_ff           <= 48'h0;
            key_prev_ff      <= 1'b0;
            reading_idx      <= 3'h0;
            secondary        <= 1'b0;
            reconfig_count   <= 5'h0;
            reconfig_ack     <= 1'b0;
            reconfig_refused <= 1'b0;
        end else begin
            state_ff         <= nxt_state;
            hold_ff          <= nxt_hold;
            tmo_ff           <= nxt_tmo;
            key_prev_ff      <= key_lvl_ff;
            reading_idx      <= nxt_idx;
            secondary        <= nxt_sec;
            reconfig_count   <= nxt_rcount;
            reconfig_ack     <= nxt_ack;
            reconfig_refused <= nxt_refused;
        end
    end

    assign test_mode   = (state_ff == tec_pkg::ST_TEST);
    assign exit_prompt = test_mode && key_lvl_ff && (hold_ff >= EXIT_CYC);    // [RULE_03]

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_entry_contact: assert property ($rose(test_mode) |-> $past(contact_lvl_ff)) // [RULE_01]
        else $error("test mode entered without shorted contact");
    a_timeout_exit: assert property (test_mode && timeout_hit |=> !test_mode && reading_idx == 3'h0) // [RULE_02]
        else $error("timeout did not leave test mode");
    a_hold_exit: assert property (test_mode && key_release && hold_ff >= EXIT_CYC |=> !test_mode) // [RULE_03]
        else $error("long hold release did not exit");
    a_brief_advance: assert property (test_mode && !secondary && key_release && hold_ff < LONG_CYC
        && !timeout_hit && reading_idx < tec_pkg::LAST_READING |=> reading_idx == $past(reading_idx) + 3'h1) // [RULE_04]
        else $error("brief press did not advance");
    a_long_toggle: assert property (test_mode && key_release && hold_ff >= LONG_CYC && hold_ff < EXIT_CYC
        && !timeout_hit |=> secondary != $past(secondary)) // [RULE_04]
        else $error("long press did not toggle readings");
    a_reconf_limit: assert property (reconfig_req && reconfig_count == tec_pkg::RECONF_MAX
        |=> reconfig_refused && reconfig_count == tec_pkg::RECONF_MAX) // [RULE_05]
        else $error("reconfiguration beyond limit accepted");
    a_hires_clear: assert property (vol_raw_ff < $past(vol_raw_ff) |-> $past(total_reset_req)) // [RULE_07]
        else $error("high resolution volume cleared without total reset");
    a_heat_sign: assert property (heat_raw_ff != $past(heat_raw_ff) && !$past(total_reset_req)
        |-> $past(meas.inlet_temp) > $past(meas.outlet_temp)) // [RULE_12]
        else $error("heat counted without positive difference");
    a_cool_sign: assert property (cool_raw_ff != $past(cool_raw_ff) && !$past(total_reset_req)
        |-> $past(meas.inlet_temp) < $past(meas.outlet_temp)) // [RULE_13]
        else $error("cooling counted without negative difference");
    a_flow_err_stop: assert property ($past(meas.flow_err) && !$past(total_reset_req)
        |-> $stable(vol_raw_ff) && $stable(inw_raw_ff) && $stable(outw_raw_ff)) // [RULE_16]
        else $error("counting continued during flow error");
    a_threshold: assert property (cfg.thr_en && meas.vol_step && !total_reset_req
        && meas.inlet_temp < cfg.heat_cool_threshold |=> $stable(heat_raw_ff)) // [RULE_18]
        else $error("heat counted below threshold");
    a_dash_flow: assert property (meas.flow_err |=> dash.flow && dash.heat && dash.volume) // [RULE_17]
        else $error("flow error not shown as dashes");

    c_enter_test: cover property ($rose(test_mode));
    c_toggle_sec: cover property ($rose(secondary));
    c_refused:    cover property (reconfig_refused);
    c_heat_count: cover property (heat_raw_ff != $past(heat_raw_ff));

endmodule // tec_calc

// >>> tec_front.sv
// Behavioural flow and temperature front end for the calculator.
// Assumes the bench asks for one volume step at a time, on core_clk.
module tec_front (
    // Clock
    input  wire logic          core_clk,
    // Bench request
    input  wire logic          step_go,
    input  wire logic [7:0]    vol,
    input  wire logic [15:0]   tin,
    input  wire logic [15:0]   tout,
    input  wire logic [2:0]    errs,
    // To calculator
    output tec_pkg::tec_meas_t meas
);
    timeunit 1ns;
    timeprecision 1ns;
    // Outlet coefficient kept zero so a wrong position pick shows up
    always_ff @(posedge core_clk) begin
        meas.vol_step    <= step_go;
        meas.flow_volume <= vol;
        meas.inlet_temp  <= tin;
        meas.outlet_temp <= tout;
        meas.k_inlet     <= 21'h11B340;
        meas.k_outlet    <= 21'h000000;
        meas.inlet_err   <= errs[0];
        meas.outlet_err  <= errs[1];
        meas.flow_err    <= errs[2];
    end
endmodule // tec_front

// >>> tec_pkg.sv
// Shared constants and carrier types for the thermal energy calculator.
// Assumes a single 10 MHz core clock and a front end that delivers volume steps.
package tec_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam longint CLK_PERIOD_NS   = 64'd100;
    localparam longint TEST_TIMEOUT_H  = 64'd9;
    localparam longint EXIT_HOLD_MS    = 64'd5000;
    localparam longint LONG_HOLD_MS    = 64'd1000;
    // Longest time rounds down, least hold times round up
    localparam longint TEST_TIMEOUT_CYC =
        (TEST_TIMEOUT_H * 64'd3600 * 64'd1000000000) / CLK_PERIOD_NS;
    localparam longint EXIT_HOLD_CYC =
        (EXIT_HOLD_MS * 64'd1000000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
    localparam longint LONG_HOLD_CYC =
        (LONG_HOLD_MS * 64'd1000000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
    localparam int     CNT_W = 48;

    ////////////////////////////////////////////////////////////////////////////
    // Counting and scaling
    localparam logic [4:0]  RECONF_MAX   = 5'd25;
    localparam logic [2:0]  LAST_READING = 3'd5;
    localparam logic [2:0]  LAST_SECOND  = 3'd2;
    // Raw energy unit is 1e-10 Wh: 10 ml x 0.01 K x 1e-6 kWh/(m3 K)
    localparam logic [63:0] WH_SCALE     = 64'h0000_0002_540B_E400;
    localparam logic [63:0] DIV_KWH      = 64'h0000_0000_0000_03E8;
    localparam logic [63:0] DIV_MWH      = 64'h0000_0000_000F_4240;
    localparam logic [63:0] DIV_GJ       = 64'h0000_0000_0004_3D28;
    // Raw weighted unit is 1e-7 m3 C; one divisor per volume resolution
    localparam logic [63:0] WDIV_RES0    = 64'h0000_0000_000F_4240;
    localparam logic [63:0] WDIV_RES1    = 64'h0000_0000_0098_9680;
    localparam logic [63:0] WDIV_RES2    = 64'h0000_0000_05F5_E100;
    localparam logic [63:0] WDIV_RES3    = 64'h0000_0000_3B9A_CA00;

    ////////////////////////////////////////////////////////////////////////////
    // Enumerations
    localparam logic [1:0] UNIT_KWH = 2'h0;
    localparam logic [1:0] UNIT_MWH = 2'h1;
    localparam logic [1:0] UNIT_GJ  = 2'h2;
    localparam logic [1:0] UNIT_WH  = 2'h3;

    typedef enum logic [1:0] {
        ST_USER = 2'b01,
        ST_TEST = 2'b10
    } tec_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic        vol_step;      // One volume count step
        logic [7:0]  flow_volume;   // Step volume, 10 ml units
        logic [15:0] inlet_temp;    // 0.01 C
        logic [15:0] outlet_temp;   // 0.01 C
        logic [20:0] k_inlet;       // 1e-6 kWh/(m3 K) at inlet temperature
        logic [20:0] k_outlet;      // 1e-6 kWh/(m3 K) at outlet temperature
        logic        inlet_err;
        logic        outlet_err;
        logic        flow_err;
    } tec_meas_t;

    typedef struct packed {
        logic        flow_at_outlet;
        logic [1:0]  flow_size_code;  // 0 finest .. 3 coarsest volume resolution
        logic [1:0]  energy_unit;
        logic        thr_en;
        logic [15:0] heat_cool_threshold;
    } tec_cfg_t;

    typedef struct packed {
        logic inlet;
        logic outlet;
        logic delta_t;
        logic flow;
        logic power;
        logic heat;
        logic cool;
        logic inlet_w;
        logic outlet_w;
        logic volume;
    } tec_dash_t;

endpackage

// >>> thermal_energy_calculator_test.sv
// Self-checking bench for the calculator core.
// Assumes tec_front as the measurement side and shortened test-mode counts.
module thermal_energy_calculator_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam longint KC = 64'h11B340;
    logic core_clk, reset_n, step_go, rst_req, rc_req, contact, key, t_req;
    logic [7:0] vol;
    logic [15:0] tin, tout;
    logic [2:0] errs, idx;
    tec_pkg::tec_meas_t meas;
    tec_pkg::tec_cfg_t cfg;
    tec_pkg::tec_dash_t dash;
    logic tmode, prompt, sec, rc_ack, rc_ref;
    logic [4:0] rc_cnt;
    logic [31:0] e_heat, e_cool, w_in, w_out, h_heat, h_cool, h_vol;
    int err_total, check_count;
    longint x_heat, x_cool, x_win, x_wout, x_vol;

    tec_front fe_u (.core_clk(core_clk), .step_go(step_go), .vol(vol), .tin(tin),
        .tout(tout), .errs(errs), .meas(meas));
    tec_calc #(.TIMEOUT_CYC(48'h7D0), .EXIT_CYC(48'hC8), .LONG_CYC(48'h32)) dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .meas(meas), .cfg(cfg),
        .total_reset_req(rst_req), .reconfig_req(rc_req), .test_contact_pin(contact),
        .key_pin(key), .test_req(t_req), .test_mode(tmode), .exit_prompt(prompt),
        .reading_idx(idx), .secondary(sec), .heat_energy_acc(e_heat),
        .cooling_energy_acc(e_cool), .inlet_weighted_acc(w_in),
        .outlet_weighted_acc(w_out), .heat_hires_wh(h_heat), .cool_hires_wh(h_cool),
        .volume_hires(h_vol), .dash(dash), .reconfig_count(rc_cnt),
        .reconfig_ack(rc_ack), .reconfig_refused(rc_ref));

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %0h got %0h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Errors stay applied after the step so dash flags can be seen
    task automatic step(logic [7:0] v, logic [15:0] a, logic [15:0] b, logic [2:0] e);
        longint lv, la, lb, kk;
        lv = v;
        la = a;
        lb = b;
        // The front end offers a zero coefficient at the outlet position
        kk = cfg.flow_at_outlet ? 64'h0 : KC;
        tick(1);
        {vol, tin, tout, errs, step_go} = {v, a, b, e, 1'b1};
        tick(1);
        step_go = 0;
        tick(6);
        if (!e[2]) x_vol += lv;
        if (!e[2] && !e[0]) x_win += lv * la;
        if (!e[2] && !e[1]) x_wout += lv * lb;
        if (e == 3'h0 && la > lb && (!cfg.thr_en || la >= cfg.heat_cool_threshold))
            x_heat += lv * (la - lb) * kk;
        if (e == 3'h0 && la < lb && (!cfg.thr_en || la < cfg.heat_cool_threshold))
            x_cool += lv * (lb - la) * kk;
        chk("heat_hires", 32'(x_heat / tec_pkg::WH_SCALE), h_heat);
        chk("cool_hires", 32'(x_cool / tec_pkg::WH_SCALE), h_cool);
        chk("vol_hires", 32'(x_vol), h_vol);
        chk("inlet_w", 32'(x_win / 64'hF4240), w_in);
        chk("outlet_w", 32'(x_wout / 64'hF4240), w_out);
        chk("dash_inw", 32'(e[0] | e[2]), 32'(dash.inlet_w));
        chk("dash_outw", 32'(e[1] | e[2]), 32'(dash.outlet_w));
        chk("dash_heat", 32'(e != 3'h0), 32'(dash.heat));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_energy();
        longint dv[4] = '{64'h3E8, 64'hF4240, 64'h43D28, 64'h1};
        longint wd = 64'hF4240;
        step(8'hFF, 16'hEA60, 16'h4E20, 3'h0);
        step(8'hFF, 16'h4E20, 16'hEA60, 3'h0);
        step(8'hFF, 16'h4E20, 16'h4E20, 3'h0);
        for (int i = 0; i < 3; i++) step(8'hFF, 16'hEA60, 16'h4E20, 3'(1 << i));
        chk("dash_flow", 32'h1, 32'(dash.flow));
        for (int u = 0; u < 4; u++) begin
            cfg.energy_unit = 2'(u);
            cfg.flow_size_code = 2'(u);
            tick(4);
            chk("heat_unit", 32'(x_heat / tec_pkg::WH_SCALE / dv[u]), e_heat);
            chk("cool_unit", 32'(x_cool / tec_pkg::WH_SCALE / dv[u]), e_cool);
            chk("inlet_res", 32'(x_win / wd), w_in);
            chk("outlet_res", 32'(x_wout / wd), w_out);
            wd = wd * 10;
        end
        cfg = '0;
        cfg.flow_at_outlet = 1;
        step(8'hFF, 16'hEA60, 16'h4E20, 3'h0);
        cfg.flow_at_outlet = 0;
        cfg.thr_en = 1;
        cfg.heat_cool_threshold = 16'hEA60;
        step(8'hFF, 16'h4E20, 16'h2710, 3'h0);
        step(8'hFF, 16'hEA60, 16'h4E20, 3'h0);
        step(8'hFF, 16'hEA60, 16'hFDE8, 3'h0);
        cfg = '0;
        step(8'h01, 16'h4E20, 16'h4E20, 3'h0);
    endtask
    task automatic t_reconf();
        for (int i = 0; i < 26; i++) begin
            rc_req = 1;
            tick(1);
            rc_req = 0;
            chk("rc_ack", 32'(i < 25), 32'(rc_ack));
            chk("rc_ref", 32'(i >= 25), 32'(rc_ref));
            tick(1);
        end
        chk("rc_cnt", 32'd25, 32'(rc_cnt));
    endtask
    task automatic press(int n);
        key = 1;
        tick(n);
        key = 0;
        tick(8);
    endtask
    task automatic enter(logic v, int lim);
        int n = 0;
        t_req = 1;
        tick(1);
        t_req = 0;
        while (tmode !== v && n < lim) begin
            tick(1);
            n++;
        end
        chk("test_mode", 32'(v), 32'(tmode));
        if (tmode !== v) close_out();
    endtask
    task automatic t_test();
        enter(0, 10);
        contact = 1;
        tick(8);
        enter(1, 5);
        press(10);
        chk("idx", 32'h1, 32'(idx));
        press(60);
        chk("sec", 32'h1, 32'(sec));
        press(60);
        chk("sec", 32'h0, 32'(sec));
        key = 1;
        tick(215);
        chk("prompt", 32'h1, 32'(prompt));
        press(1);
        chk("exit", 32'h0, 32'(tmode));
        enter(1, 5);
        press(10);
        tick(1850);
        chk("still_test", 32'h1, 32'(tmode));
        enter(0, 300);
        chk("idx0", 32'h0, 32'(idx));
    endtask
    task automatic t_hold();
        chk("hires_kept", 32'(x_heat / tec_pkg::WH_SCALE), h_heat);
        rst_req = 1;
        tick(1);
        rst_req = 0;
        tick(4);
        chk("hires_clr", 32'h0, h_vol);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        {reset_n, step_go, rst_req, rc_req, contact, key, t_req} = '0;
        {vol, tin, tout, errs} = '0;
        cfg = '0;
        tick(3);
        reset_n = 1;
        t_energy();
        t_reconf();
        t_test();
        t_hold();
        close_out();
    end
endmodule // thermal_energy_calculator_test
